// ### rtl/sre_pkg.sv
// Purpose: Shared constants and types of the serial EEPROM command engine.
// Assumes: 250 MHz system clock; link clock comes from the bus master.
// Notes:   Numbers used by the logic live here under a name, except field and synchroniser widths written in place.

package sre_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Length of the internal programming cycle, in microseconds
  localparam int unsigned PROG_TIME_US  = 100;
  // Longest time rounds down to whole cycles
  localparam int unsigned PROG_CYCLES   = (PROG_TIME_US * 1000)
                                          / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W    = 24;

  // ****************************************************************
  // Memory geometry
  // ****************************************************************
  localparam int unsigned MEM_ADDR_W    = 11;
  localparam int unsigned PAGE_ADDR_W   = 4;
  localparam int unsigned PAGE_BYTES    = 16;
  localparam int unsigned ROW_ADDR_W    = 8;
  localparam logic [7:0]  MEM_ERASED    = 8'hFF;

  // ****************************************************************
  // Select code layout
  // ****************************************************************
  // Device type code: value is arbitrary
  localparam logic [3:0]  DEV_TYPE_ID   = 4'h5;
  localparam int unsigned SEL_TYPE_LSB  = 4;
  localparam int unsigned SEL_CS_LSB    = 1;
  localparam int unsigned SEL_RW_BIT    = 0;
  localparam logic        RW_READ       = 1'b1;
  localparam logic [2:0]  CS_ALL        = 3'h7;

  // ****************************************************************
  // Bit slots within a nine-clock byte frame
  // ****************************************************************
  localparam logic [3:0]  BIT_FIRST     = 4'h0;
  localparam logic [3:0]  BIT_SECOND    = 4'h1;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;

  // Link-side command states
  typedef enum logic [2:0]
  {
    SRE_IDLE,
    SRE_SEL,
    SRE_ADDR,
    SRE_WDATA,
    SRE_RDATA
  } sre_state_t;

endpackage

// ### rtl/sre_sync.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent, slowly changing level.
// Notes:   The first stage is read by the second stage only.

`timescale 1ns/100ps
`default_nettype none

module sre_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Level in and synchronised level out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // Two flops in series to settle metastability
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule // sre_sync

`default_nettype wire

// ### rtl/sre_mem.sv
// Purpose: Byte array of the EEPROM with page commit and read port.
// Assumes: Page data and mask are quiet while commit_i is high.
// Notes:   Read data follows the captured address one cycle later.

`timescale 1ns/100ps
`default_nettype none

module sre_mem
  import sre_pkg::*;
#(
  parameter int unsigned ADDR_W = sre_pkg::MEM_ADDR_W,
  parameter int unsigned PAGE_W = sre_pkg::PAGE_ADDR_W
) (
  // Clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  // Page commit
  input  wire logic                       commit_i,
  input  wire logic [ADDR_W-PAGE_W-1:0]   page_base_i,
  input  wire logic [(1<<PAGE_W)-1:0][7:0] page_data_i,
  input  wire logic [(1<<PAGE_W)-1:0]     page_mask_i,
  // Read port
  input  wire logic                       rd_load_i,
  input  wire logic [ADDR_W-1:0]          rd_addr_i,
  output logic      [7:0]                 rd_data_o
);

  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam int unsigned PBYTES = 1 << PAGE_W;

  logic [7:0]        mem_reg [DEPTH];
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [7:0]        rd_data_reg;

  // Array starts erased; commit writes only the bytes that were latched
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= MEM_ERASED;
    end
    else if (commit_i)
    begin
      for (int i = 0; i < PBYTES; i++)
        if (page_mask_i[i])
          mem_reg[{page_base_i, PAGE_W'(i)}] <= page_data_i[i];
    end
  end

  // Read data refreshes every cycle, so a commit shows up at once
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_addr_reg <= '0;
      rd_data_reg <= MEM_ERASED;
    end
    else
    begin
      if (rd_load_i)
        rd_addr_reg <= rd_addr_i;
      rd_data_reg <= mem_reg[rd_addr_reg];
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule // sre_mem

`default_nettype wire

// ### rtl/sre_engine.sv
// Purpose: Command engine of a two-wire serial EEPROM slave.
// Assumes: A bit-level front end flags start and stop conditions.
// Notes:   Link logic runs on the bus clock; array and timer on clk_sys.

`timescale 1ns/100ps
`default_nettype none

module sre_engine
  import sre_pkg::*;
#(
  parameter int unsigned PROG_LEN = sre_pkg::PROG_CYCLES
) (
  // System clock domain
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic stop_i,
  output logic      busy_o,
  // Link clock domain
  input  wire logic scl_clk_i,
  input  wire logic start_flag_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // Board pins
  input  wire logic write_protect_input_i,
  input  wire logic chip_select_pin_0_i,
  input  wire logic chip_select_pin_1_i,
  input  wire logic chip_select_pin_2_i
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int unsigned UPPER_W = MEM_ADDR_W - ROW_ADDR_W;
  localparam logic [2:0]  CS_CMP  = 3'(CS_ALL << UPPER_W);

  sre_state_t                     state_reg,   state_next;
  logic [3:0]                     bit_reg,     bit_next;
  logic [7:0]                     shift_reg,   shift_next;
  logic [7:0]                     tx_reg,      tx_next;
  logic [MEM_ADDR_W-1:0]          addr_reg,    addr_next;
  logic                           ack_reg,     ack_next;
  logic                           slot_reg,    slot_next;
  logic                           drive_reg,   drive_next;
  logic                           tgl_reg,     tgl_next;
  logic [PAGE_BYTES-1:0][7:0]     page_reg,    page_next;
  logic [PAGE_BYTES-1:0]          mask_reg,    mask_next;
  logic                           sda_oe_reg;
  logic                           sda_out_reg;
  logic [7:0]                     rx_byte;
  logic                           sel_ok;
  logic                           busy_s;
  logic                           wp_s;
  logic [2:0]                     cs_s;

  logic                           busy_reg,    busy_next;
  logic [PROG_CNT_W-1:0]          cnt_reg,     cnt_next;
  logic                           commit_reg,  commit_next;
  logic                           armed_reg,   armed_next;
  logic                           slot_d_reg;
  logic                           tgl_d_reg;
  logic                           slot_s;
  logic                           tgl_s;
  logic                           prog_go;
  logic [7:0]                     rd_data;

  // ****************************************************************
  // Crossings
  // ****************************************************************
  // Busy, protect and chip-select pins into the link domain
  sre_sync #(.WIDTH(5)) u_sync_link (
    .clk_i   (scl_clk_i),
    .reset_i (reset_i),
    .d_i     ({busy_reg, write_protect_input_i, chip_select_pin_2_i,
                chip_select_pin_1_i, chip_select_pin_0_i}),
    .q_o     ({busy_s, wp_s, cs_s})
  );

  // Data-ack slot level and address-change toggle into clk_sys
  sre_sync #(.WIDTH(2)) u_sync_sys (
    .clk_i   (clk_sys_i),
    .reset_i (reset_i),
    .d_i     ({slot_reg, tgl_reg}),
    .q_o     ({slot_s, tgl_s})
  );

  // ****************************************************************
  // Link domain: command decode on rising bus clock
  // ****************************************************************
  // Trade-off: page bytes and the counter are read by clk_sys only
  // while the bus clock stands still after a stop, or after a toggle
  // has crossed, so they need no synchroniser of their own.
  always_comb
  begin
    rx_byte    = {shift_reg[6:0], sda_i};
    sel_ok     = (rx_byte[7:SEL_TYPE_LSB] == DEV_TYPE_ID) &&
                 (((rx_byte[SEL_CS_LSB +: 3] ^ cs_s) & CS_CMP) == 3'h0);
    state_next = state_reg;
    bit_next   = 4'(bit_reg + BIT_SECOND);
    shift_next = rx_byte;
    tx_next    = tx_reg;
    addr_next  = addr_reg;
    ack_next   = 1'b0;
    slot_next  = 1'b0;
    page_next  = page_reg;
    mask_next  = mask_reg;
    if (busy_s)
    begin
      // Deaf while programming, even to a start
      state_next = SRE_IDLE;
      bit_next   = BIT_FIRST;
    end
    else if (start_flag_i)
    begin
      // Start or repeated start: this edge carries select bit 7
      state_next = SRE_SEL;
      bit_next   = BIT_SECOND;
    end
    else
    begin
      unique case (state_reg)
        SRE_IDLE:
        begin
          bit_next = bit_reg;
        end
        SRE_SEL:
        begin
          if (bit_reg == BIT_LAST)
          begin
            if (sel_ok)
            begin
              ack_next = 1'b1;
              if (rx_byte[SEL_RW_BIT] == RW_READ)
                state_next = SRE_RDATA;
              else
              begin
                state_next = SRE_ADDR;
                // Upper address bits ride in the chip-select slots
                addr_next  = MEM_ADDR_W'({rx_byte[SEL_CS_LSB +: 3],
                               addr_reg[ROW_ADDR_W-1:0]});
                mask_next  = '0;
              end
            end
            else
              state_next = SRE_IDLE;
          end
        end
        SRE_ADDR:
        begin
          if (bit_reg == BIT_LAST)
          begin
            addr_next[ROW_ADDR_W-1:0] = rx_byte;
            ack_next   = 1'b1;
            state_next = SRE_WDATA;
          end
          else if (bit_reg == BIT_ACK)
            bit_next = BIT_FIRST;
        end
        SRE_WDATA:
        begin
          if (bit_reg == BIT_LAST)
          begin
            if (!wp_s)
            begin
              ack_next = 1'b1;
              // Latest byte wins if the page rolls over
              page_next[addr_reg[PAGE_ADDR_W-1:0]] = rx_byte;
              mask_next[addr_reg[PAGE_ADDR_W-1:0]] = 1'b1;
              addr_next[PAGE_ADDR_W-1:0] =
                addr_reg[PAGE_ADDR_W-1:0] + 1'b1;
            end
          end
          else if (bit_reg == BIT_ACK)
          begin
            bit_next  = BIT_FIRST;
            // Only the gap after an accepted data ack may commit
            slot_next = ack_reg;
          end
          else if (bit_reg == BIT_FIRST)
            // A stop needs one more clock pulse; keep the slot open
            slot_next = slot_reg;
        end
        SRE_RDATA:
        begin
          if (bit_reg == BIT_ACK)
          begin
            bit_next = BIT_FIRST;
            if (ack_reg || !sda_i)
              tx_next = rd_data;
            else
              state_next = SRE_IDLE;
          end
          else
          begin
            tx_next = {tx_reg[6:0], 1'b0};
            if (bit_reg == BIT_LAST)
              addr_next = addr_reg + 1'b1;
          end
        end
        default:
        begin
          state_next = SRE_IDLE;
        end
      endcase
    end
    tgl_next   = tgl_reg ^ (addr_next != addr_reg);
    drive_next = ack_next ||
                 (state_next == SRE_RDATA && bit_next <= BIT_LAST &&
                  !tx_next[7]);
  end

  // Link-domain state registers
  always_ff @(posedge scl_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= SRE_IDLE;
      bit_reg   <= BIT_FIRST;
      shift_reg <= '0;
      tx_reg    <= MEM_ERASED;
      addr_reg  <= '0;
      ack_reg   <= 1'b0;
      slot_reg  <= 1'b0;
      drive_reg <= 1'b0;
      tgl_reg   <= 1'b0;
      page_reg  <= '0;
      mask_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      addr_reg  <= addr_next;
      ack_reg   <= ack_next;
      slot_reg  <= slot_next;
      drive_reg <= drive_next;
      tgl_reg   <= tgl_next;
      page_reg  <= page_next;
      mask_reg  <= mask_next;
    end
  end

  // Data line changes only while the bus clock is low
  always_ff @(negedge scl_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end
    else
    begin
      sda_oe_reg  <= drive_reg && !busy_s;
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_oe_o = sda_oe_reg;
  assign sda_o    = sda_out_reg;

  // ****************************************************************
  // System domain: programming timer
  // ****************************************************************
  always_comb
  begin
    prog_go     = stop_i && armed_reg && !busy_reg &&
                  (mask_reg != '0);
    armed_next  = armed_reg;
    busy_next   = busy_reg;
    cnt_next    = cnt_reg;
    commit_next = 1'b0;
    // Arm once per data-ack slot so a bare repeat stop cannot rewrite
    if (slot_s && !slot_d_reg)
      armed_next = 1'b1;
    else if (prog_go || !slot_s)
      armed_next = 1'b0;
    if (prog_go)
    begin
      busy_next   = 1'b1;
      commit_next = 1'b1;
      cnt_next    = PROG_CNT_W'(PROG_LEN - 1);
    end
    else if (busy_reg)
    begin
      if (cnt_reg == '0)
        busy_next = 1'b0;
      else
        cnt_next = cnt_reg - 1'b1;
    end
  end

  // System-domain registers
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy_reg   <= 1'b0;
      cnt_reg    <= '0;
      commit_reg <= 1'b0;
      armed_reg  <= 1'b0;
      slot_d_reg <= 1'b0;
      tgl_d_reg  <= 1'b0;
    end
    else
    begin
      busy_reg   <= busy_next;
      cnt_reg    <= cnt_next;
      commit_reg <= commit_next;
      armed_reg  <= armed_next;
      slot_d_reg <= slot_s;
      tgl_d_reg  <= tgl_s;
    end
  end

  assign busy_o = busy_reg;

  // Protected bytes never reach the mask, so the array keeps them
  sre_mem #(
    .ADDR_W (MEM_ADDR_W),
    .PAGE_W (PAGE_ADDR_W)
  ) u_mem (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .commit_i    (commit_reg),
    .page_base_i (addr_reg[MEM_ADDR_W-1:PAGE_ADDR_W]),
    .page_data_i (page_reg),
    .page_mask_i (mask_reg),
    .rd_load_i   (tgl_s ^ tgl_d_reg),
    .rd_addr_i   (addr_reg),
    .rd_data_o   (rd_data)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_sel_ack: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    (state_reg == SRE_SEL && bit_reg == BIT_LAST && sel_ok && !busy_s &&
     !start_flag_i) |=> ack_reg ##1 (bit_reg == BIT_FIRST))
    else $error("select match not acknowledged");

  a_prog_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    prog_go |=> busy_reg && commit_reg ##1 busy_reg && !commit_reg)
    else $error("programming did not start on stop");

  a_prog_cause: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(busy_reg) |-> $past(stop_i) && $past(slot_s))
    else $error("programming started outside data-ack slot");

  a_busy_deaf: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    busy_s |=> state_reg == SRE_IDLE && !ack_reg && !drive_reg)
    else $error("bus answered while programming");

  a_wp_nack: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    (state_reg == SRE_WDATA && bit_reg == BIT_LAST && wp_s && !busy_s &&
     !start_flag_i) |=> !ack_reg && $stable(mask_reg))
    else $error("protected data byte acknowledged");

  a_page_wrap: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    (state_reg == SRE_WDATA && bit_reg == BIT_LAST && !wp_s && !busy_s &&
     !start_flag_i) |=> ack_reg &&
    addr_reg[PAGE_ADDR_W-1:0] ==
      PAGE_ADDR_W'($past(addr_reg[PAGE_ADDR_W-1:0]) + 1'b1)
    && $stable(addr_reg[MEM_ADDR_W-1:PAGE_ADDR_W]))
    else $error("page address not wrapped in low bits");

  a_read_incr: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    (state_reg == SRE_RDATA && bit_reg == BIT_LAST && !busy_s &&
     !start_flag_i) |=> addr_reg == MEM_ADDR_W'($past(addr_reg) + 1'b1))
    else $error("read counter did not advance");

  a_read_nack: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    (state_reg == SRE_RDATA && bit_reg == BIT_ACK && !ack_reg && sda_i &&
     !busy_s && !start_flag_i) |=> state_reg == SRE_IDLE ##1 !sda_oe_reg)
    else $error("read continued after master nack");

  a_sel_miss: assert property (@(posedge scl_clk_i) disable iff (reset_i)
    (state_reg == SRE_SEL && bit_reg == BIT_LAST && !sel_ok &&
     !start_flag_i) |=> !ack_reg && state_reg == SRE_IDLE)
    else $error("mismatched select code answered");

  a_prog_len: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(busy_reg) |-> cnt_reg == PROG_CNT_W'(PROG_LEN - 1) &&
    $past(!busy_reg))
    else $error("programming length wrong");

  c_commit:   cover property (@(posedge clk_sys_i) disable iff (reset_i)
    prog_go);
  c_poll:     cover property (@(posedge scl_clk_i) disable iff (reset_i)
    busy_s && start_flag_i);
  c_seq_read: cover property (@(posedge scl_clk_i) disable iff (reset_i)
    state_reg == SRE_RDATA && bit_reg == BIT_ACK && !ack_reg && !sda_i);
  c_wp_write: cover property (@(posedge scl_clk_i) disable iff (reset_i)
    state_reg == SRE_WDATA && bit_reg == BIT_LAST && wp_s);

endmodule // sre_engine

`default_nettype wire

// ### verif/sre_master.sv
// Purpose: Behavioural two-wire bus master for the command engine.
// Assumes: SCL idles high and stands still between frames.
// Notes:   Stop reaches the engine as a one-cycle clk_sys pulse.
`timescale 1ns/100ps
`default_nettype none
module sre_master (
  // Stop pulse clock and wire level
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  // Link side
  output logic      scl_o,
  output logic      start_o,
  output logic      sda_o,
  output logic      stop_o
);
  // Idle bus: released data line, clock parked high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    start_o = 1'b0;
    stop_o = 1'b0;
  end
  // One nine-clock frame; after the start, data moves only while SCL is low
  task automatic xfer(input logic st, input logic [7:0] b, input logic slot,
                      output logic [7:0] rd, output logic ack);
    if (st)
      sda_o = 1'b0;
    #40;
    for (int i = 8; i >= 0; i--)
    begin
      scl_o = 1'b0;
      #40;
      sda_o = (i == 0) ? slot : b[i-1];
      start_o = st && (i == 8);
      #40;
      if (i > 0)
        rd[i-1] = sda_i;
      else
        ack = ~sda_i;
      scl_o = 1'b1;
      #80;
    end
  endtask
  // Stop: data rises while SCL is high, then SCL stands still
  task automatic stop;
    scl_o = 1'b0;
    #40;
    sda_o = 1'b0;
    #40;
    scl_o = 1'b1;
    #40;
    sda_o = 1'b1;
    @(posedge clk_sys_i);
    #1 stop_o = 1'b1;
    @(posedge clk_sys_i);
    #1 stop_o = 1'b0;
  endtask
endmodule // sre_master
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench of the EEPROM command engine.
// Assumes: Shortened programming length keeps polling brief.
// Notes:   Expected bytes come from a bench-side array model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sre_pkg::*;
  localparam int unsigned PLEN = 2000;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic scl, st_f, m_sda, stop_p, busy, oe, sda, ack, dsda;
  logic [7:0] exp_q[$];
  logic [7:0] seen, rd, ev, b;
  logic [7:0] mem [2048];
  logic [10:0] cnt = 11'h0;
  string seen_n;
  event res_ev;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  // Pull-up wire: low while either side pulls it
  assign sda = m_sda & (~oe | dsda);
  always #2 clk_sys_i = ~clk_sys_i;
  sre_master m_u (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
    .start_o(st_f), .sda_o(m_sda), .stop_o(stop_p));
  sre_engine #(.PROG_LEN(PLEN)) dut_u (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .stop_i(stop_p), .busy_o(busy), .scl_clk_i(scl),
    .start_flag_i(st_f), .sda_i(sda), .sda_o(dsda), .sda_oe_o(oe),
    .write_protect_input_i(wp), .chip_select_pin_0_i(cs[0]),
    .chip_select_pin_1_i(cs[1]), .chip_select_pin_2_i(cs[2]));
  // Compare each result with the oldest note
  always @(res_ev)
  begin
    ev = exp_q.pop_front();
    checked++;
    if (seen !== ev)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", seen_n, ev, seen);
    end
  end
  // Hang guard; a full run needs about 25000 cycles
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rep(input string n, input logic [7:0] s);
    seen_n = n;
    seen = s;
    ->res_ev;
    #1;
  endtask
  // One frame with its expected ack or data byte noted first
  task automatic op(input logic st, input logic [7:0] v, input logic sl,
                    input logic [7:0] e, input logic is_rd);
    exp_q.push_back(e);
    m_u.xfer(st, v, sl, rd, ack);
    rep(is_rd ? "rdata" : "ack", is_rd ? rd : {7'h0, ack});
  endtask
  task automatic bchk(input logic e);
    exp_q.push_back({7'h0, e});
    rep("busy", {7'h0, busy});
  endtask
  task automatic load(input logic [10:0] a);
    op(1'b1, {DEV_TYPE_ID, a[10:8], 1'b0}, 1'b1, 8'h01, 1'b0);
    op(1'b0, a[7:0], 1'b1, 8'h01, 1'b0);
    cnt = a;
  endtask
  // Stop; if programming, poll until the select is acked again
  task automatic stop_poll(input logic prog);
    m_u.stop();
    repeat (20) @(posedge clk_sys_i);
    #1;
    bchk(prog);
    if (prog)
    begin
      // Poll with the counter's own upper bits so it is left in place
      op(1'b1, {DEV_TYPE_ID, cnt[10:8], 1'b0}, 1'b1, 8'h00,
         1'b0);
      repeat (20)
      begin
        m_u.xfer(1'b1, {DEV_TYPE_ID, cnt[10:8], 1'b0}, 1'b1, rd, ack);
        if (ack)
          break;
      end
      exp_q.push_back(8'h01);
      rep("ack", {7'h0, ack});
      stop_poll(1'b0);
    end
  endtask
  task automatic wr(input logic [10:0] a, input int n);
    load(a);
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom_range(127));
      op(1'b0, b, 1'b1, {7'h0, ~wp}, 1'b0);
      if (!wp)
      begin
        mem[cnt] = b;
        cnt[3:0] = cnt[3:0] + 4'h1;
      end
    end
    stop_poll(!wp);
  endtask
  // Random or current read of n bytes, nack on the last
  task automatic rdn(input logic rnd, input logic [10:0] a, input int n,
                     input logic extra);
    if (rnd)
      load(a);
    op(1'b1, {DEV_TYPE_ID, cnt[10:8], 1'b1}, 1'b1, 8'h01,
       1'b0);
    for (int i = 0; i < n; i++)
    begin
      op(1'b0, 8'hFF, i == n - 1, mem[cnt], 1'b1);
      cnt = cnt + 11'h1;
    end
    if (extra)
      op(1'b0, 8'hFF, 1'b1, 8'hFF, 1'b1);
    m_u.stop();
  endtask
  initial
  begin
    void'($urandom(41938));
    foreach (mem[i])
      mem[i] = MEM_ERASED;
    cs = 3'($urandom());
    repeat (5) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    #1000;
    rdn(1'b1, 11'h7FE, 3, 1'b0);
    wr(11'h12C, 6);
    rdn(1'b0, 11'h0, 1, 1'b0);
    rdn(1'b1, 11'h12A, 4, 1'b1);
    wp = 1'b1;
    wr(11'h055, 2);
    rdn(1'b1, 11'h055, 1, 1'b0);
    wp = 1'b0;
    wr(11'h000, 1);
    rdn(1'b1, 11'h7FF, 2, 1'b0);
    wr(11'h300, 1);
    load(11'h300);
    stop_poll(1'b0);
    rdn(1'b0, 11'h0, 1, 1'b0);
    op(1'b1, {~DEV_TYPE_ID, 4'h1}, 1'b1, 8'h00, 1'b0);
    m_u.stop();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
